// ===== rtl/smc_pkg.sv
// Constants, register map and decode functions of the signal modulator carrier select block.
// Assumes a single core clock domain. All users reference items as smc_pkg::name.
package smc_pkg;

  // ==========================================================================
  // Register map
  localparam int          ADDR_W        = 2;
  localparam int          DATA_W        = 8;
  localparam logic [1:0]  OFS_CONTROL   = 2'h0;
  localparam logic [1:0]  OFS_SOURCE    = 2'h1;
  localparam logic [1:0]  OFS_HI_CARR   = 2'h2;
  localparam logic [1:0]  OFS_LO_CARR   = 2'h3;

  // ==========================================================================
  // Carrier control fields
  localparam int          CAR_PIN_OFF   = 7;
  localparam int          CAR_INVERT    = 6;
  localparam int          CAR_SYNC_EN   = 5;
  localparam int          CAR_SEL_HI    = 3;
  localparam logic [7:0]  CAR_WR_MASK   = 8'hEF;

  // ==========================================================================
  // Modulator control fields
  localparam int          CTL_ENABLE    = 7;
  localparam int          CTL_PIN_EN    = 6;
  localparam int          CTL_SLEW      = 5;
  localparam int          CTL_OUT_INV   = 4;
  localparam int          CTL_READBACK  = 3;
  localparam int          CTL_SW_BIT    = 0;
  localparam logic [7:0]  CTL_WR_MASK   = 8'hF1;
  localparam logic [7:0]  CTL_RESET     = 8'h20;

  // ==========================================================================
  // Modulation source fields
  localparam int          SRC_PIN_OFF   = 7;
  localparam logic [7:0]  SRC_WR_MASK   = 8'h8F;
  localparam logic [7:0]  CFG_POR_VALUE = 8'h00;

  // ==========================================================================
  // Source encodings
  localparam logic [3:0]  MOD_SW_BIT    = 4'h0;
  localparam logic [3:0]  MOD_PIN       = 4'h1;
  localparam logic [3:0]  MOD_PERIPH_LO = 4'h2;
  localparam logic [3:0]  MOD_PERIPH_HI = 4'hA;
  localparam int          MOD_PERIPH_N  = 9;
  localparam logic [3:0]  CAR_GND       = 4'h0;
  localparam logic [3:0]  CAR_PIN_A     = 4'h1;
  localparam logic [3:0]  CAR_PIN_B     = 4'h2;
  localparam logic [3:0]  CAR_REF_CLK   = 4'h3;
  localparam logic [3:0]  CAR_PWM_BASE  = 4'h4;
  localparam int          PWM_N         = 4;

  typedef enum logic [1:0] {
    SMC_SEL_HIGH = 2'b01,
    SMC_SEL_LOW  = 2'b10
  } smc_mix_type;

  // Carrier source pick; srcs[0] is ground, top half of the code space is open
  function automatic logic smc_carrier_pick(input logic [3:0] sel, input logic [7:0] srcs);
    return sel[CAR_SEL_HI] ? 1'b0 : srcs[sel[2:0]];
  endfunction

  // One-hot decode of a selection code onto a PWM unit
  function automatic logic [PWM_N-1:0] smc_pwm_hit(input logic [3:0] sel);
    logic [PWM_N-1:0] hit;
    hit = '0;
    for (int i = 0; i < PWM_N; i++) begin
      if (sel == CAR_PWM_BASE + 4'(i)) begin
        hit[i] = 1'b1;
      end
    end
    return hit;
  endfunction

endpackage

// ===== rtl/smc_sync.sv
// Two-flop synchroniser bank for carrier and modulation inputs.
// Assumes inputs may toggle at any time relative to core_clk.
`timescale 1ns/10ps
module smc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ==========================================================================
  // Per-bit double register
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta;
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          meta        <= 1'b0;
          sync_out[g] <= 1'b0;
        end else if (clk_en) begin
          meta        <= async_in[g];
          sync_out[g] <= meta;
        end
      end
    end
  endgenerate

endmodule // smc_sync

// ===== rtl/smc_carrier.sv
// One carrier path: source selection, polarity and falling edge detection.
// Assumes synchronised sources and PWM outputs already gated by PWM mode.
`timescale 1ns/10ps
module smc_carrier (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       clk_en,
  input  wire logic [3:0] sel,
  input  wire logic       invert,
  input  wire logic [7:0] srcs,
  output logic            raw,
  output logic            level,
  output logic            fall
);

  logic prev;

  // ==========================================================================
  // Selection and polarity
  assign raw   = smc_pkg::smc_carrier_pick(sel, srcs);
  assign level = raw ^ invert;

  // ==========================================================================
  // Falling edge of the conditioned carrier
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prev <= 1'b0;
    end else if (clk_en) begin
      prev <= level;
    end
  end

  assign fall = prev & ~level;

endmodule // smc_carrier

// ===== rtl/smc_modulator.sv
// Signal modulator carrier select and mixer with its four control registers.
// Assumes a plain register port in the core_clk domain and synchronous PWM mode flags.
`timescale 1ns/10ps
module smc_modulator (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       por_n,
  input  wire logic       clk_en,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       carrier_in_pin_a,
  input  wire logic       carrier_in_pin_b,
  input  wire logic       modulation_in_pin,
  input  wire logic       ref_clk_signal,
  input  wire logic [3:0] pwm_out,
  input  wire logic [3:0] pwm_mode_active,
  input  wire logic [8:0] mod_periph_out,
  output logic            mod_out,
  output logic            mod_out_oe,
  output logic            output_slew_limit,
  output logic [3:0]      pwm_pin_off,
  output logic            ref_clk_pin_off,
  output logic [8:0]      mod_periph_pin_off
);

  // ==========================================================================
  // Declarations
  localparam int SYNC_W = 8 + smc_pkg::MOD_PERIPH_N;

  logic [7:0]             ctl_reg;
  logic [7:0]             src_reg;
  logic [7:0]             hi_reg;
  logic [7:0]             lo_reg;
  logic                   any_reset_n;
  logic [SYNC_W-1:0]      sync_in;
  logic [SYNC_W-1:0]      sync_q;
  logic                   s_pin_a;
  logic                   s_pin_b;
  logic                   s_mod_pin;
  logic                   s_ref_clk;
  logic [3:0]             s_pwm;
  logic [8:0]             s_periph;
  logic [7:0]             car_srcs;
  logic                   hi_raw;
  logic                   hi_level;
  logic                   hi_fall;
  logic                   lo_raw;
  logic                   lo_level;
  logic                   lo_fall;
  logic                   mod_bit;
  smc_pkg::smc_mix_type   mix_state;
  smc_pkg::smc_mix_type   next_mix_state;
  logic                   mixed;
  logic                   out_q;
  logic [7:0]             next_rdata;

  wire logic              ctl_en   = ctl_reg[smc_pkg::CTL_ENABLE];
  wire logic              hi_sync  = hi_reg[smc_pkg::CAR_SYNC_EN];
  wire logic              lo_sync  = lo_reg[smc_pkg::CAR_SYNC_EN];
  wire logic [3:0]        hi_sel   = hi_reg[3:0];
  wire logic [3:0]        lo_sel   = lo_reg[3:0];
  wire logic [3:0]        ms_sel   = src_reg[3:0];

  // Power-on resets everything, ordinary reset all but the source and carrier registers
  assign any_reset_n = resetn & por_n;

  // ==========================================================================
  // Register writes
  always_ff @(posedge core_clk or negedge any_reset_n) begin
    if (!any_reset_n) begin
      ctl_reg <= smc_pkg::CTL_RESET;
    end else if (clk_en && reg_wr && reg_addr == smc_pkg::OFS_CONTROL) begin
      ctl_reg <= reg_wdata & smc_pkg::CTL_WR_MASK;
    end
  end

  // Configuration survives resetn and is cleared only by power-on
  always_ff @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      src_reg <= smc_pkg::CFG_POR_VALUE;
      hi_reg  <= smc_pkg::CFG_POR_VALUE;
      lo_reg  <= smc_pkg::CFG_POR_VALUE;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == smc_pkg::OFS_SOURCE) begin
        src_reg <= reg_wdata & smc_pkg::SRC_WR_MASK;
      end else if (reg_addr == smc_pkg::OFS_HI_CARR) begin
        hi_reg <= reg_wdata & smc_pkg::CAR_WR_MASK;
      end else if (reg_addr == smc_pkg::OFS_LO_CARR) begin
        lo_reg <= reg_wdata & smc_pkg::CAR_WR_MASK;
      end
    end
  end

  // ==========================================================================
  // Register reads
  always_comb begin
    next_rdata = 8'h00;
    if (reg_addr == smc_pkg::OFS_CONTROL) begin
      next_rdata = ctl_reg;
      next_rdata[smc_pkg::CTL_READBACK] = out_q;
    end else if (reg_addr == smc_pkg::OFS_SOURCE) begin
      next_rdata = src_reg;
    end else if (reg_addr == smc_pkg::OFS_HI_CARR) begin
      next_rdata = hi_reg;
    end else if (reg_addr == smc_pkg::OFS_LO_CARR) begin
      next_rdata = lo_reg;
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge any_reset_n) begin
    if (!any_reset_n) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? next_rdata : 8'h00;
    end
  end

  // ==========================================================================
  // Input synchronisers
  assign sync_in = {mod_periph_out, pwm_out, ref_clk_signal, modulation_in_pin,
                    carrier_in_pin_b, carrier_in_pin_a};

  smc_sync #(
    .WIDTH    (SYNC_W)
  ) u_sync (
    .core_clk (core_clk),
    .resetn   (any_reset_n),
    .clk_en   (clk_en),
    .async_in (sync_in),
    .sync_out (sync_q)
  );

  assign s_pin_a   = sync_q[0];
  assign s_pin_b   = sync_q[1];
  assign s_mod_pin = sync_q[2];
  assign s_ref_clk = sync_q[3];
  assign s_pwm     = sync_q[7:4];
  assign s_periph  = sync_q[SYNC_W-1:8];

  // ==========================================================================
  // Carrier paths
  // PWM outputs count only while their unit is in PWM mode
  assign car_srcs = {s_pwm & pwm_mode_active, s_ref_clk, s_pin_b, s_pin_a, 1'b0};

  smc_carrier u_hi (
    .core_clk (core_clk),
    .resetn   (any_reset_n),
    .clk_en   (clk_en),
    .sel      (hi_sel),
    .invert   (hi_reg[smc_pkg::CAR_INVERT]),
    .srcs     (car_srcs),
    .raw      (hi_raw),
    .level    (hi_level),
    .fall     (hi_fall)
  );

  smc_carrier u_lo (
    .core_clk (core_clk),
    .resetn   (any_reset_n),
    .clk_en   (clk_en),
    .sel      (lo_sel),
    .invert   (lo_reg[smc_pkg::CAR_INVERT]),
    .srcs     (car_srcs),
    .raw      (lo_raw),
    .level    (lo_level),
    .fall     (lo_fall)
  );

  // ==========================================================================
  // Modulation source
  always_comb begin
    mod_bit = 1'b0;
    if (ms_sel == smc_pkg::MOD_SW_BIT) begin
      mod_bit = ctl_reg[smc_pkg::CTL_SW_BIT];
    end else if (ms_sel == smc_pkg::MOD_PIN) begin
      mod_bit = s_mod_pin;
    end else if (ms_sel <= smc_pkg::MOD_PERIPH_HI) begin
      mod_bit = s_periph[ms_sel - smc_pkg::MOD_PERIPH_LO];
    end
  end

  // ==========================================================================
  // Carrier switching
  always_comb begin
    next_mix_state = mix_state;
    case (mix_state)
      smc_pkg::SMC_SEL_HIGH: begin
        if (!mod_bit && (!ctl_en || !hi_sync || hi_fall)) begin
          next_mix_state = smc_pkg::SMC_SEL_LOW;
        end
      end
      smc_pkg::SMC_SEL_LOW: begin
        if (mod_bit && (!ctl_en || !lo_sync || lo_fall)) begin
          next_mix_state = smc_pkg::SMC_SEL_HIGH;
        end
      end
      default: begin
        next_mix_state = smc_pkg::SMC_SEL_LOW;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge any_reset_n) begin
    if (!any_reset_n) begin
      mix_state <= smc_pkg::SMC_SEL_LOW;
    end else if (clk_en) begin
      mix_state <= next_mix_state;
    end
  end

  assign mixed = (mix_state == smc_pkg::SMC_SEL_HIGH) ? hi_level : lo_level;

  // ==========================================================================
  // Output stage
  always_ff @(posedge core_clk or negedge any_reset_n) begin
    if (!any_reset_n) begin
      out_q <= 1'b0;
    end else if (clk_en) begin
      out_q <= ctl_en & (mixed ^ ctl_reg[smc_pkg::CTL_OUT_INV]);
    end
  end

  assign mod_out           = out_q;
  assign mod_out_oe        = ctl_en & ctl_reg[smc_pkg::CTL_PIN_EN];
  assign output_slew_limit = ctl_reg[smc_pkg::CTL_SLEW];

  // ==========================================================================
  // Peripheral pin suppression
  always_ff @(posedge core_clk or negedge any_reset_n) begin
    if (!any_reset_n) begin
      pwm_pin_off        <= 4'h0;
      ref_clk_pin_off    <= 1'b0;
      mod_periph_pin_off <= 9'h000;
    end else if (clk_en) begin
      pwm_pin_off <= ({4{hi_reg[smc_pkg::CAR_PIN_OFF]}} & smc_pkg::smc_pwm_hit(hi_sel))
                   | ({4{lo_reg[smc_pkg::CAR_PIN_OFF]}} & smc_pkg::smc_pwm_hit(lo_sel));
      ref_clk_pin_off <= (hi_reg[smc_pkg::CAR_PIN_OFF] && hi_sel == smc_pkg::CAR_REF_CLK)
                       || (lo_reg[smc_pkg::CAR_PIN_OFF] && lo_sel == smc_pkg::CAR_REF_CLK);
      for (int i = 0; i < smc_pkg::MOD_PERIPH_N; i++) begin
        mod_periph_pin_off[i] <= src_reg[smc_pkg::SRC_PIN_OFF]
                               && ms_sel == smc_pkg::MOD_PERIPH_LO + 4'(i);
      end
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!any_reset_n);

  sequence s_hi_waiting;
    clk_en && ctl_en && mix_state == smc_pkg::SMC_SEL_HIGH && !mod_bit;
  endsequence

  sequence s_lo_waiting;
    clk_en && ctl_en && mix_state == smc_pkg::SMC_SEL_LOW && mod_bit;
  endsequence

  a_disabled_output_low: assert property (
    clk_en && !ctl_en |=> !mod_out)
    else $error("output active while modulator disabled");

  a_output_mix_high: assert property (
    clk_en && ctl_en && mix_state == smc_pkg::SMC_SEL_HIGH
      |=> mod_out == ($past(hi_level) ^ $past(ctl_reg[smc_pkg::CTL_OUT_INV])))
    else $error("output does not follow high carrier");

  a_hi_sync_hold: assert property (
    s_hi_waiting ##0 (hi_sync && !hi_fall) |=> mix_state == smc_pkg::SMC_SEL_HIGH)
    else $error("switched to low carrier before high carrier fell");

  a_hi_switch_now: assert property (
    s_hi_waiting ##0 (!hi_sync || hi_fall) |=> mix_state == smc_pkg::SMC_SEL_LOW)
    else $error("switch to low carrier missed");

  a_lo_sync_hold: assert property (
    s_lo_waiting ##0 (lo_sync && !lo_fall) |=> mix_state == smc_pkg::SMC_SEL_LOW)
    else $error("switched to high carrier before low carrier fell");

  a_lo_switch_now: assert property (
    s_lo_waiting ##0 (!lo_sync || lo_fall) |=> mix_state == smc_pkg::SMC_SEL_HIGH)
    else $error("switch to high carrier missed");

  a_silent_codes: assert property (
    (hi_sel[smc_pkg::CAR_SEL_HI] || hi_sel == smc_pkg::CAR_GND) |-> !hi_raw)
    else $error("reserved or ground carrier code not silent");

  a_lo_silent_codes: assert property (
    (lo_sel[smc_pkg::CAR_SEL_HI] || lo_sel == smc_pkg::CAR_GND) |-> !lo_raw)
    else $error("reserved or ground low carrier code not silent");

  a_pin_a_invert: assert property (
    lo_sel == smc_pkg::CAR_PIN_A |-> lo_level == (s_pin_a ^ lo_reg[smc_pkg::CAR_INVERT]))
    else $error("low carrier does not follow first carrier pin");

  a_unimpl_bit_zero: assert property (
    clk_en && reg_rd && reg_addr[1] |=> !reg_rdata[4])
    else $error("unimplemented carrier bit reads as one");

  a_pwm_pin_off: assert property (
    any_reset_n && clk_en && hi_reg[smc_pkg::CAR_PIN_OFF]
      && hi_sel[3:2] == smc_pkg::CAR_PWM_BASE[3:2]
      |=> pwm_pin_off[$past(hi_sel[1:0])])
    else $error("high carrier PWM pin not suppressed");

  a_sync_two_flops: assert property (
    (any_reset_n && clk_en) ##1 clk_en |=> s_pin_a == $past(carrier_in_pin_a, 2))
    else $error("carrier pin not delayed by two flops");

endmodule // smc_modulator

// ===== tb/smc_far_end.sv
// Far side of the carrier select block: carrier pins, reference clock and PWM units.
// Assumes the bench sets static levels through hold, or lets the reference clock run.
`timescale 1ns/10ps
module smc_far_end (
  input  wire logic       hold,
  input  wire logic [6:0] level,
  input  wire logic [3:0] pwm_mode,
  output logic            carrier_in_pin_a,
  output logic            carrier_in_pin_b,
  output logic            ref_clk_signal,
  output logic [3:0]      pwm_out,
  output logic [3:0]      pwm_mode_active
);
  // ==========================================================================
  // Free running reference clock, unrelated in phase to core_clk
  logic ref_run;

  initial begin
    ref_run = 1'b0;
    // Offset keeps every toggle clear of the core_clk edges
    #7;
    forever #65 ref_run = ~ref_run;
  end

  // ==========================================================================
  // Pin levels; PWM mode flag is passed straight through from the bench's pwm_mode input
  always_comb begin
    carrier_in_pin_a = level[0];
    carrier_in_pin_b = level[1];
    ref_clk_signal   = hold ? level[2] : ref_run;
    pwm_out          = level[6:3];
    pwm_mode_active  = pwm_mode;
  end
endmodule // smc_far_end

// ===== tb/tb.sv
// Self-checking bench of the signal modulator carrier select block.
// Assumes the far end model drives all carrier sources; registers use the plain port.
`timescale 1ns/10ps
module tb;
  typedef struct packed {
    logic [7:0]  ctl;
    logic [7:0]  src;
    logic [7:0]  hi;
    logic [7:0]  lo;
    logic [3:0]  pma;
    logic        exp;
    logic [13:0] off;
  } smc_row_type;

  logic        core_clk, resetn, por_n, clk_en, reg_wr, reg_rd, hold;
  logic [1:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [6:0]  level;
  logic [3:0]  pwm_mode, pwm_out, pwm_mode_active, pwm_pin_off;
  logic [8:0]  mod_periph_pin_off;
  logic        pin_a, pin_b, ref_clk, mod_out, mod_out_oe, slew, ref_off;
  int          err_total, tests_run, flips;
  logic [1:0]  ref_hist;
  smc_row_type rows[31];

  // ==========================================================================
  // Design and far end
  smc_modulator DUT (
    .core_clk(core_clk), .resetn(resetn), .por_n(por_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .carrier_in_pin_a(pin_a), .carrier_in_pin_b(pin_b),
    .modulation_in_pin(1'b1), .ref_clk_signal(ref_clk), .pwm_out(pwm_out),
    .pwm_mode_active(pwm_mode_active), .mod_periph_out(9'h001), .mod_out(mod_out),
    .mod_out_oe(mod_out_oe), .output_slew_limit(slew), .pwm_pin_off(pwm_pin_off),
    .ref_clk_pin_off(ref_off), .mod_periph_pin_off(mod_periph_pin_off));

  smc_far_end far (
    .hold(hold), .level(level), .pwm_mode(pwm_mode), .carrier_in_pin_a(pin_a),
    .carrier_in_pin_b(pin_b), .ref_clk_signal(ref_clk), .pwm_out(pwm_out),
    .pwm_mode_active(pwm_mode_active));

  // ==========================================================================
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(16'(reg_rdata), 16'(exp));
    cyc(1);
    chk(16'(reg_rdata), 16'h0000);
  endtask

  task automatic pulse_reset(input logic full);
    @(posedge core_clk);
    resetn <= 1'b0;
    por_n  <= ~full;
    cyc(2);
    chk(16'({mod_out, mod_out_oe, slew}), 16'h0001);
    @(posedge core_clk);
    resetn <= 1'b1;
    por_n  <= 1'b1;
  endtask

  task automatic sync_case(input logic s);
    level <= s ? 7'h02 : 7'h01;
    wr(0, {7'h40, ~s});
    wr(2, s ? 8'h01 : 8'h21);
    wr(3, s ? 8'h22 : 8'h02);
    cyc(6);
    chk(16'(mod_out), 16'h0001);
    wr(0, {7'h40, s});
    repeat (10) begin
      cyc(1);
      chk(16'(mod_out), 16'h0001);
    end
    level <= 7'h00;
    cyc(6);
    chk(16'(mod_out), 16'h0000);
    level <= s ? 7'h02 : 7'h01;
    cyc(6);
    chk(16'(mod_out), 16'h0000);
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // Clock, watchdog and sequence
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  initial begin
    #2000000;
    err_total++;
    summarize();
  end

  initial begin
    // Sources: pin_a 1, pin_b 0, ref 1, PWM units 1..4 = 1,0,1,0
    rows = '{
      '{8'h81, 8'h00, 8'h00, 8'h00, 4'hF, 1'b0, 14'h0000},
      '{8'h81, 8'h00, 8'h01, 8'h00, 4'hF, 1'b1, 14'h0000},
      '{8'h81, 8'h00, 8'h02, 8'h00, 4'hF, 1'b0, 14'h0000},
      '{8'h81, 8'h00, 8'h03, 8'h00, 4'hF, 1'b1, 14'h0000},
      '{8'h81, 8'h00, 8'h04, 8'h00, 4'hF, 1'b1, 14'h0000},
      '{8'h81, 8'h00, 8'h05, 8'h00, 4'hF, 1'b0, 14'h0000},
      '{8'h81, 8'h00, 8'h06, 8'h00, 4'hF, 1'b1, 14'h0000},
      '{8'h81, 8'h00, 8'h07, 8'h00, 4'hF, 1'b0, 14'h0000},
      '{8'h81, 8'h00, 8'h09, 8'h00, 4'hF, 1'b0, 14'h0000},
      '{8'h81, 8'h00, 8'h0B, 8'h00, 4'hF, 1'b0, 14'h0000},
      '{8'h81, 8'h00, 8'h04, 8'h00, 4'h0, 1'b0, 14'h0000},
      '{8'hC1, 8'h00, 8'h42, 8'h00, 4'hF, 1'b1, 14'h0000},
      '{8'hE1, 8'h00, 8'h86, 8'h00, 4'hF, 1'b1, 14'h0004},
      '{8'h81, 8'h00, 8'h83, 8'h00, 4'hF, 1'b1, 14'h0010},
      '{8'h80, 8'h00, 8'h00, 8'h01, 4'hF, 1'b1, 14'h0000},
      '{8'h80, 8'h00, 8'h01, 8'h00, 4'hF, 1'b0, 14'h0000},
      '{8'h80, 8'h00, 8'h01, 8'h06, 4'hF, 1'b1, 14'h0000},
      '{8'h80, 8'h00, 8'h01, 8'h07, 4'hF, 1'b0, 14'h0000},
      '{8'h80, 8'h00, 8'h01, 8'h0B, 4'hF, 1'b0, 14'h0000},
      '{8'h80, 8'h00, 8'h01, 8'h42, 4'hF, 1'b1, 14'h0000},
      '{8'h80, 8'h00, 8'h01, 8'h85, 4'hF, 1'b0, 14'h0002},
      '{8'h91, 8'h00, 8'h01, 8'h00, 4'hF, 1'b0, 14'h0000},
      '{8'h41, 8'h00, 8'h01, 8'h00, 4'hF, 1'b0, 14'h0000},
      '{8'h51, 8'h00, 8'h01, 8'h00, 4'hF, 1'b0, 14'h0000},
      '{8'h80, 8'h01, 8'h01, 8'h02, 4'hF, 1'b1, 14'h0000},
      '{8'h80, 8'h0B, 8'h01, 8'h02, 4'hF, 1'b0, 14'h0000},
      '{8'h80, 8'h02, 8'h01, 8'h02, 4'hF, 1'b1, 14'h0000},
      '{8'h80, 8'h03, 8'h01, 8'h02, 4'hF, 1'b0, 14'h0000},
      '{8'h80, 8'h82, 8'h01, 8'h02, 4'hF, 1'b1, 14'h0020},
      '{8'h80, 8'h8A, 8'h01, 8'h02, 4'hF, 1'b0, 14'h2000},
      '{8'h81, 8'h00, 8'h02, 8'h00, 4'hF, 1'b0, 14'h0000}};
    {resetn, por_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {clk_en, hold, level, pwm_mode} = {1'b1, 1'b1, 7'h2D, 4'hF};
    err_total = 0;
    tests_run = 0;
    repeat (12) @(posedge core_clk);
    chk(16'({mod_out, mod_out_oe, slew}), 16'h0001);
    resetn <= 1'b1;
    por_n  <= 1'b1;
    rd(0, 8'h20);
    for (int a = 1; a < 4; a++) rd(2'(a), 8'h00);
    wr(0, 8'h77);
    for (int a = 1; a < 4; a++) wr(2'(a), 8'hFF);
    rd(0, 8'h71);
    rd(1, 8'h8F);
    rd(2, 8'hEF);
    rd(3, 8'hEF);
    pulse_reset(1'b0);
    rd(0, 8'h20);
    rd(1, 8'h8F);
    rd(2, 8'hEF);
    rd(3, 8'hEF);
    pulse_reset(1'b1);
    for (int a = 1; a < 4; a++) rd(2'(a), 8'h00);
    foreach (rows[i]) begin
      wr(0, rows[i].ctl);
      wr(1, rows[i].src);
      wr(2, rows[i].hi);
      wr(3, rows[i].lo);
      pwm_mode <= rows[i].pma;
      cyc(6);
      chk(16'(mod_out), 16'(rows[i].exp));
      chk(16'({mod_out_oe, slew}), 16'({rows[i].ctl[7] & rows[i].ctl[6], rows[i].ctl[5]}));
      chk(16'({mod_periph_pin_off, ref_off, pwm_pin_off}), 16'(rows[i].off));
      rd(0, (rows[i].ctl & 8'hF1) | {4'h0, rows[i].exp, 3'h0});
    end
    sync_case(1'b0);
    sync_case(1'b1);
    // Free running reference clock must pass straight to the output
    hold <= 1'b0;
    wr(2, 8'h03);
    wr(0, 8'h81);
    cyc(6);
    // Output shows the reference level sampled two edges earlier
    flips = 0;
    for (int j = 0; j < 42; j++) begin
      cyc(1);
      if (j > 1 && mod_out !== ref_hist[1]) flips++;
      ref_hist = {ref_hist[0], ref_clk};
    end
    chk(16'(flips), 16'h0000);
    summarize();
  end
endmodule // tb
